//--- design/standard_timer_pkg.sv
/*
  Package for the standard timer: register offsets, field positions,
  reset values, mode codes and the state struct.
  Assumes an AXI4-Lite slave with 32-bit data, one register per word.
*/
package standard_timer_pkg;
  localparam logic [3:0] OFFSET_CONTROL_0   = 4'h0;
  localparam logic [3:0] OFFSET_CONTROL_1   = 4'h4;
  localparam logic [3:0] OFFSET_COUNT_LOW   = 4'h8;
  localparam logic [3:0] OFFSET_COUNT_HIGH  = 4'hC;
  localparam logic [5:0] OFFSET_CMP_A_LOW   = 6'h10;
  localparam logic [5:0] OFFSET_CMP_A_HIGH  = 6'h14;
  localparam logic [5:0] OFFSET_PERIOD_BYTE = 6'h18;
  localparam logic [5:0] OFFSET_FLAGS       = 6'h1C;

  localparam int BIT_PAUSE      = 7;
  localparam int BIT_ENABLE     = 3;
  localparam int BIT_MODE_HI    = 7;
  localparam int BIT_MODE_LO    = 6;
  localparam int BIT_PIN_HI     = 5;
  localparam int BIT_PIN_LO     = 4;
  localparam int BIT_INIT_LEVEL = 3;
  localparam int BIT_INVERT     = 2;
  localparam int BIT_SWAP       = 1;
  localparam int BIT_CLEAR_SEL  = 0;
  localparam int BIT_FLAG_A     = 0;
  localparam int BIT_FLAG_P     = 1;

  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [15:0] RESET_COUNT  = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;

  localparam logic [1:0] PIN_NO_CHANGE = 2'h0;
  localparam logic [1:0] PIN_LOW       = 2'h1;
  localparam logic [1:0] PIN_HIGH      = 2'h2;
  localparam logic [1:0] PIN_TOGGLE    = 2'h3;
  localparam logic [1:0] PIN_PWM       = 2'h2;
  localparam logic [1:0] PIN_PULSE     = 2'h3;

  // bus write phase, gray coded along idle -> collect -> respond
  typedef enum logic [1:0] {
    WR_IDLE    = 2'b00,
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b11
  } write_phase_type;

  typedef struct packed {
    logic [7:0]      control_0;
    logic [7:0]      control_1;
    logic [7:0]      compare_a_low_byte;
    logic [7:0]      compare_a_high_byte;
    logic [7:0]      period_compare_byte;
    logic [15:0]     count;
    logic            enable_prev;
    logic            pin_level;
    logic            match_a_flag;
    logic            match_p_flag;
    logic            ext_prev;
    write_phase_type wr_phase;
    logic            aw_held;
    logic            w_held;
    logic [5:0]      aw_addr;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } timer_state_type;

  localparam timer_state_type STATE_RESET = '{
    control_0: 8'h00, control_1: 8'h00, compare_a_low_byte: 8'h00,
    compare_a_high_byte: 8'h00, period_compare_byte: 8'h00,
    count: 16'h0000, enable_prev: 1'b0, pin_level: 1'b0,
    match_a_flag: 1'b0, match_p_flag: 1'b0, ext_prev: 1'b0,
    wr_phase: WR_IDLE, aw_held: 1'b0, w_held: 1'b0, aw_addr: 6'h00,
    w_data: 32'h0000_0000, w_strb: 4'h0, bresp: 2'h0, rvalid: 1'b0,
    rdata: 32'h0000_0000, rresp: 2'h0
  };
endpackage : standard_timer_pkg

//--- design/standard_timer.sv
/*
  Standard 16-bit timer with compare A, 8-bit period compare P, compare
  output, timer/counter, PWM and single-pulse modes; AXI4-Lite registers.
  Assumes one clock; count_tick and external_count_pin are synchronous.
*/
// Implementation choices: the register offsets and the AXI4-Lite slave port.
// Summary of operation
// - compare value A is 16 bits, two byte registers, reset to zero
// - compare value P matches only counter bits 15 to 8
// - clear select low: P match clears counter; P zero overflows full range
// - mode 00 compare output; clear select low raises both A and P flags
// - clear select high: A match clears counter, only A flag raised
// - A equal zero: counter overflows at FFFF, no A flag
// - compare output mode: besides enable rise, pin changes only on A match per pin function
// - compare and single pulse modes: enable rising edge sets pin to the initial level bit xor the invert bit
// - mode 11 behaves as compare mode but never drives the pin
// - swap low: period is P times 256 or 65536, A sets duty
// - duty at or above period gives continuously active output
// - swap high: A sets period, P times 256 or 65536 sets duty
// - PWM raises A and P flags on matches; clear select ignored
// - PWM pin functions 00 and 01 force inactive or active level
// - PWM initial level bit picks active level; invert bit inverts pin
// - single pulse: external pin edge sets the enable bit
// - pulse ends on enable clear or A match; A match clears enable, flags
// - single pulse: counter zeroed only by enable rise; P, swap ignored
// - compare output codes: no change, low, high, toggle
// - enable rise zeroes counter; enable low holds counter value
`timescale 1ns/100ps
module standard_timer #(
  parameter int COUNT_WIDTH = 16
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        count_tick,
  input  wire logic        external_count_pin,
  output logic             timer_out,
  output logic             timer_out_enable,
  output logic             match_a_event,
  output logic             match_p_event,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  standard_timer_pkg::timer_state_type state_q;
  standard_timer_pkg::timer_state_type state_d;

  logic [1:0]             mode;
  logic [1:0]             pin_fn;
  logic [COUNT_WIDTH-1:0] cmp_a;
  logic [COUNT_WIDTH:0]   p_span;
  logic                   a_match;
  logic                   p_match;
  logic                   pulse_mode;
  logic                   pwm_mode;
  logic                   active;
  logic                   raw_level;
  logic                   ext_edge;
  logic                   enable_now;
  logic                   clear_now;
  logic                   do_write;
  logic [5:0]             wr_addr;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;

  function automatic logic [31:0] read_word(
    input standard_timer_pkg::timer_state_type s,
    input logic [5:0]                          addr
  );
    case (addr)
      {2'h0, standard_timer_pkg::OFFSET_CONTROL_0}:
        read_word = {24'h000000, s.control_0[7:3], 3'h0};
      {2'h0, standard_timer_pkg::OFFSET_CONTROL_1}:  read_word = {24'h000000, s.control_1};
      {2'h0, standard_timer_pkg::OFFSET_COUNT_LOW}:  read_word = {24'h000000, s.count[7:0]};
      {2'h0, standard_timer_pkg::OFFSET_COUNT_HIGH}: read_word = {24'h000000, s.count[15:8]};
      standard_timer_pkg::OFFSET_CMP_A_LOW:   read_word = {24'h000000, s.compare_a_low_byte};
      standard_timer_pkg::OFFSET_CMP_A_HIGH:  read_word = {24'h000000, s.compare_a_high_byte};
      standard_timer_pkg::OFFSET_PERIOD_BYTE: read_word = {24'h000000, s.period_compare_byte};
      standard_timer_pkg::OFFSET_FLAGS:
        read_word = {30'h0, s.match_p_flag, s.match_a_flag};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  function automatic logic mapped(input logic [5:0] addr);
    mapped = (addr[1:0] == 2'h0) && (addr <= standard_timer_pkg::OFFSET_FLAGS);
  endfunction : mapped

  assign mode       = state_q.control_1[standard_timer_pkg::BIT_MODE_HI:
                                        standard_timer_pkg::BIT_MODE_LO];
  assign pin_fn     = state_q.control_1[standard_timer_pkg::BIT_PIN_HI:
                                        standard_timer_pkg::BIT_PIN_LO];
  assign cmp_a      = {state_q.compare_a_high_byte, state_q.compare_a_low_byte};
  assign pwm_mode   = (mode == standard_timer_pkg::MODE_PWM)
                      && (pin_fn != standard_timer_pkg::PIN_PULSE);
  assign pulse_mode = (mode == standard_timer_pkg::MODE_PWM)
                      && (pin_fn == standard_timer_pkg::PIN_PULSE);
  assign active     = state_q.control_0[standard_timer_pkg::BIT_ENABLE]
                      && !state_q.control_0[standard_timer_pkg::BIT_PAUSE]
                      && count_tick;
  // P compared to top byte; zero span is the full 65536 range
  assign p_span     = (state_q.period_compare_byte == 8'h00) ? 17'h10000
                      : {1'b0, state_q.period_compare_byte, 8'h00};
  assign a_match    = active && (cmp_a != 16'h0000)
                      && (state_q.count == cmp_a - 16'h0001);
  assign p_match    = active && ({1'b0, state_q.count} == p_span - 17'h00001);
  assign ext_edge   = external_count_pin && !state_q.ext_prev;

  // bus write lands when both halves have been collected
  always_comb begin
    do_write = 1'b0;
    wr_addr  = state_q.aw_addr;
    wr_data  = state_q.w_data;
    wr_strb  = state_q.w_strb;
    if (state_q.wr_phase == standard_timer_pkg::WR_COLLECT
        && state_q.aw_held && state_q.w_held) begin
      do_write = 1'b1;
    end
  end

  assign s_axi_awready = (state_q.wr_phase != standard_timer_pkg::WR_RESP) && !state_q.aw_held;
  assign s_axi_wready  = (state_q.wr_phase != standard_timer_pkg::WR_RESP) && !state_q.w_held;
  assign s_axi_bvalid  = (state_q.wr_phase == standard_timer_pkg::WR_RESP);
  assign s_axi_bresp   = state_q.bresp;
  assign s_axi_arready = !state_q.rvalid;
  assign s_axi_rvalid  = state_q.rvalid;
  assign s_axi_rdata   = state_q.rdata;
  assign s_axi_rresp   = state_q.rresp;
  assign timer_out_enable = (mode == standard_timer_pkg::MODE_COMPARE)
                            || (mode == standard_timer_pkg::MODE_PWM);
  assign timer_out     = state_q.pin_level;
  assign match_a_event = state_q.match_a_flag;
  assign match_p_event = state_q.match_p_flag;

  always_comb begin
    state_d = state_q;
    state_d.ext_prev = external_count_pin;
    state_d.match_a_flag = 1'b0;
    state_d.match_p_flag = 1'b0;
    clear_now = 1'b0;
    raw_level = 1'b0;

    // register writes
    case (state_q.wr_phase)
      standard_timer_pkg::WR_IDLE, standard_timer_pkg::WR_COLLECT: begin
        if (s_axi_awvalid && s_axi_awready) begin
          state_d.aw_held = 1'b1;
          state_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          state_d.w_held = 1'b1;
          state_d.w_data = s_axi_wdata;
          state_d.w_strb = s_axi_wstrb;
        end
        if (state_d.aw_held || state_d.w_held) begin
          state_d.wr_phase = standard_timer_pkg::WR_COLLECT;
        end
        if (do_write) begin
          state_d.aw_held  = 1'b0;
          state_d.w_held   = 1'b0;
          state_d.wr_phase = standard_timer_pkg::WR_RESP;
          state_d.bresp    = mapped(wr_addr) ? standard_timer_pkg::RESP_OKAY
                                             : standard_timer_pkg::RESP_SLVERR;
          if (wr_strb[0]) begin
            case (wr_addr)
              {2'h0, standard_timer_pkg::OFFSET_CONTROL_0}:
                state_d.control_0 = {wr_data[7:3], 3'h0};
              {2'h0, standard_timer_pkg::OFFSET_CONTROL_1}: state_d.control_1 = wr_data[7:0];
              standard_timer_pkg::OFFSET_CMP_A_LOW:  state_d.compare_a_low_byte = wr_data[7:0];
              standard_timer_pkg::OFFSET_CMP_A_HIGH: state_d.compare_a_high_byte = wr_data[7:0];
              standard_timer_pkg::OFFSET_PERIOD_BYTE:
                state_d.period_compare_byte = wr_data[7:0];
              default: state_d.bresp = state_d.bresp;
            endcase
          end
        end
      end
      standard_timer_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          state_d.wr_phase = standard_timer_pkg::WR_IDLE;
        end
      end
      default: state_d.wr_phase = standard_timer_pkg::WR_IDLE;
    endcase

    // register reads, one outstanding
    if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !state_q.rvalid) begin
      state_d.rvalid = 1'b1;
      state_d.rdata  = read_word(state_q, s_axi_araddr);
      state_d.rresp  = mapped(s_axi_araddr) ? standard_timer_pkg::RESP_OKAY
                                            : standard_timer_pkg::RESP_SLVERR;
    end

    // hardware enable set/clear wins over the same-cycle software write
    if (pulse_mode && ext_edge) begin
      state_d.control_0[standard_timer_pkg::BIT_ENABLE] = 1'b1;
    end

    // counting and matching
    if (active) begin
      state_d.count = state_q.count + 16'h0001;
      if (pulse_mode) begin
        if (a_match) begin
          state_d.match_a_flag = 1'b1;
          state_d.control_0[standard_timer_pkg::BIT_ENABLE] = 1'b0;
        end
      end else if (pwm_mode) begin
        state_d.match_a_flag = a_match;
        state_d.match_p_flag = p_match;
        clear_now = state_q.control_1[standard_timer_pkg::BIT_SWAP] ? a_match : p_match;
      end else if (mode != standard_timer_pkg::MODE_CAPTURE) begin
        if (state_q.control_1[standard_timer_pkg::BIT_CLEAR_SEL]) begin
          state_d.match_a_flag = a_match;
          clear_now = a_match;
        end else begin
          state_d.match_a_flag = a_match;
          state_d.match_p_flag = p_match;
          clear_now = p_match;
        end
        // pin moves only on an A match
        if (a_match && mode == standard_timer_pkg::MODE_COMPARE) begin
          case (pin_fn)
            standard_timer_pkg::PIN_LOW:    state_d.pin_level = 1'b0;
            standard_timer_pkg::PIN_HIGH:   state_d.pin_level = 1'b1;
            standard_timer_pkg::PIN_TOGGLE: state_d.pin_level = !state_q.pin_level;
            default:                        state_d.pin_level = state_q.pin_level;
          endcase
        end
      end else begin
        clear_now = p_match;
        state_d.match_p_flag = p_match;
      end
      if (clear_now) begin
        state_d.count = 16'h0000;
      end
    end

    // PWM level: period counter, duty compare
    if (pwm_mode) begin
      if (state_q.control_1[standard_timer_pkg::BIT_SWAP]) begin
        raw_level = ({1'b0, state_q.count} < p_span) || ({1'b0, cmp_a} <= p_span);
      end else begin
        raw_level = ({1'b0, state_q.count} < {1'b0, cmp_a}) || ({1'b0, cmp_a} >= p_span);
      end
      case (pin_fn)
        standard_timer_pkg::PIN_NO_CHANGE: raw_level = 1'b0;
        standard_timer_pkg::PIN_LOW:       raw_level = 1'b1;
        default:                           raw_level = raw_level;
      endcase
      // active level from the initial-level bit, then inversion
      state_d.pin_level = (raw_level ~^ state_q.control_1[standard_timer_pkg::BIT_INIT_LEVEL])
                          ^ state_q.control_1[standard_timer_pkg::BIT_INVERT];
    end
    if (pulse_mode) begin
      state_d.pin_level = (state_d.control_0[standard_timer_pkg::BIT_ENABLE]
                           ~^ state_q.control_1[standard_timer_pkg::BIT_INIT_LEVEL])
                          ^ state_q.control_1[standard_timer_pkg::BIT_INVERT];
    end

    // enable rising edge zeroes counter and, in compare mode, restores initial pin level
    enable_now = state_d.control_0[standard_timer_pkg::BIT_ENABLE];
    state_d.enable_prev = enable_now;
    if (enable_now && !state_q.enable_prev) begin
      state_d.count = standard_timer_pkg::RESET_COUNT;
      if (mode == standard_timer_pkg::MODE_COMPARE) begin
        state_d.pin_level = state_q.control_1[standard_timer_pkg::BIT_INIT_LEVEL]
                            ^ state_q.control_1[standard_timer_pkg::BIT_INVERT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= standard_timer_pkg::STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  AST_A_CLEARS: assert property (@(posedge clk) disable iff (reset)
    (a_match && !pulse_mode && state_q.control_1[0] && mode != 2'h1 && !pwm_mode)
      |=> (state_q.count == 16'h0000 || $rose(state_q.enable_prev)) && state_q.match_a_flag)
    else $error("A match did not clear counter");
  AST_NO_A_FLAG_ZERO: assert property (@(posedge clk) disable iff (reset)
    (cmp_a == 16'h0000) |=> !state_q.match_a_flag)
    else $error("A flag raised with zero compare A");
  AST_NO_P_FLAG_SEL: assert property (@(posedge clk) disable iff (reset)
    (mode == 2'h0 && state_q.control_1[0]) |=> !state_q.match_p_flag)
    else $error("P flag raised with clear select high");
  AST_P_TOP_BYTE: assert property (@(posedge clk) disable iff (reset)
    p_match |-> state_q.count[7:0] == 8'hFF)
    else $error("P match off a 256 boundary");
  AST_ENABLE_ZERO: assert property (@(posedge clk) disable iff (reset)
    (state_d.control_0[3] && !state_q.enable_prev) |=> state_q.count == 16'h0000)
    else $error("enable rise did not zero counter");
  AST_HOLD_OFF: assert property (@(posedge clk) disable iff (reset)
    (!state_q.control_0[3] && !state_d.control_0[3]) |=> $stable(state_q.count))
    else $error("counter moved while disabled");
  AST_PULSE_END: assert property (@(posedge clk) disable iff (reset)
    (pulse_mode && a_match && !ext_edge) |=> !state_q.control_0[3] && state_q.match_a_flag)
    else $error("A match did not end pulse");
  AST_TIMER_NO_PIN: assert property (@(posedge clk) disable iff (reset)
    (mode == 2'h3 && !do_write) |=> $stable(state_q.pin_level) && !timer_out_enable)
    else $error("pin driven in timer mode");
  // compare mode
  AST_CMP_A_FLAG: assert property (@(posedge clk) disable iff (reset)
    (mode == 2'h0 && a_match) |=> state_q.match_a_flag)
    else $error("A match raised no A flag");
  AST_CMP_P_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (mode == 2'h0 && !state_q.control_1[0] && p_match)
      |=> state_q.match_p_flag && state_q.count == 16'h0000)
    else $error("P match did not clear counter or raise P flag");
  AST_PIN_ONLY_A: assert property (@(posedge clk) disable iff (reset)
    (mode == 2'h0 && !a_match && !(state_d.control_0[3] && !state_q.enable_prev))
      |=> $stable(state_q.pin_level))
    else $error("pin moved without an A match");
  AST_PIN_TOGGLE: assert property (@(posedge clk) disable iff (reset)
    (mode == 2'h0 && a_match && pin_fn == 2'h3)
      |=> state_q.pin_level != $past(state_q.pin_level))
    else $error("toggle function did not toggle pin");
  AST_PIN_LOW: assert property (@(posedge clk) disable iff (reset)
    (mode == 2'h0 && a_match && pin_fn == 2'h1) |=> !state_q.pin_level)
    else $error("drive low function left pin high");
  AST_PIN_HIGH: assert property (@(posedge clk) disable iff (reset)
    (mode == 2'h0 && a_match && pin_fn == 2'h2) |=> state_q.pin_level)
    else $error("drive high function left pin low");
  AST_INIT_LEVEL: assert property (@(posedge clk) disable iff (reset)
    (mode == 2'h0 && state_d.control_0[3] && !state_q.enable_prev)
      |=> state_q.pin_level == ($past(state_q.control_1[3]) ^ $past(state_q.control_1[2])))
    else $error("enable rise did not restore initial pin level");
  // pwm and single pulse
  AST_PWM_A_FLAG: assert property (@(posedge clk) disable iff (reset)
    (pwm_mode && a_match) |=> state_q.match_a_flag)
    else $error("PWM A match raised no A flag");
  AST_PWM_P_FLAG: assert property (@(posedge clk) disable iff (reset)
    (pwm_mode && p_match) |=> state_q.match_p_flag)
    else $error("PWM P match raised no P flag");
  AST_PWM_FULL: assert property (@(posedge clk) disable iff (reset)
    (pwm_mode && pin_fn == 2'h2 && state_q.control_1[3:1] == 3'h4
     && {1'b0, cmp_a} >= p_span) |=> state_q.pin_level)
    else $error("duty at or above period not fully active");
  AST_PWM_INACTIVE: assert property (@(posedge clk) disable iff (reset)
    (pwm_mode && pin_fn == 2'h0)
      |=> state_q.pin_level != ($past(state_q.control_1[3]) ^ $past(state_q.control_1[2])))
    else $error("forced inactive level not on pin");
  AST_PWM_ACTIVE: assert property (@(posedge clk) disable iff (reset)
    (pwm_mode && pin_fn == 2'h1)
      |=> state_q.pin_level == ($past(state_q.control_1[3]) ^ $past(state_q.control_1[2])))
    else $error("forced active level not on pin");
  AST_PWM_SWAP_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (pwm_mode && state_q.control_1[1] && a_match) |=> state_q.count == 16'h0000)
    else $error("A match did not end swapped PWM period");
  AST_PULSE_START: assert property (@(posedge clk) disable iff (reset)
    (pulse_mode && ext_edge && !a_match) |=> state_q.control_0[3])
    else $error("trigger edge did not set enable");
  // counting
  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (reset)
    (active && !clear_now) |=> state_q.count == $past(state_q.count) + 16'h0001)
    else $error("counter did not step on a tick");
endmodule : standard_timer

//--- bench/pin_load.sv
/*
  Pin load and trigger source for the standard timer: counts cycles in
  which the pin is driven high, and makes the trigger edge on request.
  Assumes the timer clock and a synchronous clear from the bench.
*/
`timescale 1ns/100ps
module pin_load (
  input  wire logic        clk,
  input  wire logic        clear,
  input  wire logic        fire,
  input  wire logic        timer_out,
  input  wire logic        timer_out_enable,
  output logic             external_count_pin,
  output logic [15:0]      high_count
);
  // undriven pin counts as not high, so a released pin never adds
  always_ff @(posedge clk) begin
    external_count_pin <= fire;
    if (clear) begin
      high_count <= 16'h0000;
    end else if (timer_out_enable === 1'h1 && timer_out === 1'h1) begin
      high_count <= high_count + 16'h0001;
    end
  end
endmodule : pin_load

//--- bench/standard_timer_tb_top.sv
/*
  Self-checking bench for the standard timer: bus tasks, a table of
  mode runs measured by the pin load, and a single pulse run.
  Assumes the bus latencies and offsets of the designer's note.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module standard_timer_tb_top;
  logic        clk = 1'h0, reset = 1'h1, clear = 1'h0, fire = 1'h0;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, timer_out, toe, ma, mp, ext;
  logic [1:0]  bresp, rresp, r, b;
  logic [15:0] high_count;
  int          num_errors = 0, n_tests = 0, na, np, i;

  always #12.5 clk = ~clk;

  standard_timer u_standard_timer (.clk(clk), .reset(reset), .count_tick(1'h1),
    .external_count_pin(ext), .timer_out(timer_out), .timer_out_enable(toe),
    .match_a_event(ma), .match_p_event(mp), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  pin_load u_pin_load (.clk(clk), .clear(clear), .fire(fire), .timer_out(timer_out),
    .timer_out_enable(toe), .external_count_pin(ext), .high_count(high_count));

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    int n;
    logic aw_go, w_go, b_go;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // readies judged mid-cycle, where they have settled, then acted on at the edge
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid;
      b = bresp;
      @(posedge clk);
      if (aw_go) awvalid <= 1'h0;
      if (w_go) wvalid <= 1'h0;
      if (b_go) break;
    end
    bready <= 1'h0;
    if (n == 50) begin
      num_errors++;
      stop_test();
    end
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    logic ar_go, r_go;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      ar_go = arvalid && arready;
      r_go = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar_go) arvalid <= 1'h0;
      if (r_go) break;
    end
    rready <= 1'h0;
    if (n == 50) begin
      num_errors++;
      stop_test();
    end
  endtask : rd

  // window is whole periods, so the phase at which it opens does not matter
  task automatic measure(input int win, input logic trig);
    na = 0;
    np = 0;
    @(posedge clk);
    clear <= 1'h1;
    fire <= trig;
    @(posedge clk);
    clear <= 1'h0;
    fire <= 1'h0;
    repeat (win) begin
      @(negedge clk);
      if (ma === 1'h1) na++;
      if (mp === 1'h1) np++;
    end
    @(posedge clk);
    #1;
  endtask : measure

  task automatic run(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p,
                     input int win, input int hi, input int ea, input int ep);
    wr(6'h00, 8'h00);
    wr(6'h04, c1);
    wr(6'h10, a[7:0]);
    wr(6'h14, a[15:8]);
    wr(6'h18, p);
    wr(6'h00, 8'h08);
    repeat (10) @(posedge clk);
    measure(win, 1'h0);
    `CHK(high_count, hi[15:0])
    `CHK(na, ea)
    `CHK(np, ep)
  endtask : run

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    for (i = 0; i < 3; i++) begin
      rd(6'h10 + 6'(4 * i), d, r);
      `CHK(d, 32'h0000_0000)
      wr(6'h10 + 6'(4 * i), 8'hA5 + 8'(i));
      `CHK(b, standard_timer_pkg::RESP_OKAY)
      rd(6'h10 + 6'(4 * i), d, r);
      `CHK(d, {24'h000000, 8'hA5 + 8'(i)})
    end
    rd(6'h20, d, r);
    `CHK(r, standard_timer_pkg::RESP_SLVERR)
    wr(6'h20, 8'h00);
    `CHK(b, standard_timer_pkg::RESP_SLVERR)
    run(8'h39, 16'h0105, 8'h01, 522, 261, 2, 0);
    run(8'h09, 16'h0005, 8'h00, 100, 100, 20, 0);
    run(8'h19, 16'h0005, 8'h00, 100, 0, 20, 0);
    run(8'h29, 16'h0005, 8'h00, 100, 100, 20, 0);
    run(8'h38, 16'h0003, 8'h01, 512, 256, 2, 2);
    run(8'hF8, 16'h0003, 8'h01, 512, 0, 2, 2);
    run(8'hA9, 16'h0040, 8'h01, 256, 64, 1, 1);
    run(8'hA8, 16'h0200, 8'h01, 256, 256, 0, 1);
    run(8'hAC, 16'h0040, 8'h01, 256, 192, 1, 1);
    run(8'h98, 16'h0040, 8'h01, 256, 256, 1, 1);
    run(8'h88, 16'h0040, 8'h01, 256, 0, 1, 1);
    run(8'hAA, 16'h0200, 8'h01, 512, 256, 1, 1);
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    wr(6'h04, 8'hBB);
    wr(6'h10, 8'h14);
    wr(6'h18, 8'h01);
    measure(100, 1'h1);
    `CHK(high_count, 16'h0014)
    `CHK(na, 1)
    rd(6'h00, d, r);
    `CHK(d[3], 1'h0)
    stop_test();
  end
endmodule : standard_timer_tb_top
